//--- onoff_supervisor_defs.vh
// constants for the on/off supervisor and watchdog
`ifndef ONOFF_SUPERVISOR_DEFS_VH
`define ONOFF_SUPERVISOR_DEFS_VH

// clock rate in kHz (20 MHz)
`define CLK_KHZ 20000
// debounce and hold times in ms
`define CHARGER_DB_MS 120
`define EN_DB_MS 30
`define SHIP_EXIT_HOLD_MS 250
`define GPI_DB_MS 30
`define CHARGER_DB_CYC (`CHARGER_DB_MS * `CLK_KHZ)
`define EN_DB_CYC (`EN_DB_MS * `CLK_KHZ)
`define SHIP_EXIT_CYC (`SHIP_EXIT_HOLD_MS * `CLK_KHZ)
`define GPI_DB_CYC (`GPI_DB_MS * `CLK_KHZ)
// watchdog base period in seconds, cycles per second
`define WDT_BASE_S 16
`define CYC_PER_S 20000000
// watchdog period select reset value: 128 s
`define WDOG_PERIOD_RST 2'h3
// software control codes
`define SFT_NONE 2'h0
`define SFT_COLD_RESET 2'h1
`define SFT_POWER_OFF 2'h2
`define SFT_SHIP 2'h3
// charger status valid / absent codes
`define CHARGER_VALID 2'h3
`define CHARGER_ABSENT 2'h0
// channel enable codes
`define EN_FORCE_OFF_A 3'h4
`define EN_FORCE_OFF_B 3'h5
`define EN_FORCE_ON_A 3'h6
`define EN_FORCE_ON_B 3'h7
// number of output channels, general inputs
`define NUM_CH 4
`define NUM_GPI 2

`endif

//--- input_debouncer.v
// two-edge debouncer with input synchroniser
`timescale 1ns/100ps
`default_nettype none

module input_debouncer #(
  parameter [31:0] DB_CYC = 32'h0000_0010,
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk_sys, // system clock
  input wire arst_n, // asynchronous reset, active low
  input wire raw_in, // unsynchronised input
  input wire bypass, // pass synchronised level without waiting
  output reg level_q // debounced level
);

  reg sync1_q;
  reg sync2_q;
  reg [31:0] cnt_q;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= RST_VAL;
      sync2_q <= RST_VAL;
      cnt_q <= 32'h0000_0000;
      level_q <= RST_VAL;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      // RULE14 restart on change
      if (sync2_q == level_q) begin
        cnt_q <= 32'h0000_0000;
      end else if (bypass || cnt_q >= DB_CYC - 32'h0000_0001) begin
        // RULE13 both edges
        level_q <= sync2_q;
        cnt_q <= 32'h0000_0000;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

endmodule // input_debouncer

`default_nettype wire

//--- onoff_supervisor_watchdog.v
// on/off supervisor: forced channels, ship state, debounce, watchdog
// How it works
// RULE1 - enable code 6 or 7 turns channel on once always-on supply is good
// RULE2 - any forced-on channel raises the main bias request
// RULE3 - enable code 4 or 5 holds channel off regardless of sequencer
// RULE4 - host requests ship state by writing 3 to software control
// RULE5 - ship with valid charger: cut battery, keep rail fed from charger
// RULE6 - ship with no valid charger: cut battery, rail left to decay
// RULE7 - entering ship state pulses the always-on reset
// RULE8 - host bus access is blocked while in ship state
// RULE9 - ship exit allowed only after system rail below 1.8V
// RULE10 - charger status going 0 to 3 after 120ms debounce exits ship
// RULE11 - enable pin held 250ms beyond its debounce exits ship
// RULE12 - battery below 1.8V releases ship state
// RULE13 - enable pin, charger and enabled general inputs debounced both edges
// RULE14 - debounced output changes only after a full stable period
// RULE15 - watchdog expiry forces shutdown and resets configuration
// RULE16 - host sets watchdog enable bit to start the timer
// RULE17 - watchdog period select picks 16, 32, 64 or 128 seconds
// RULE18 - watchdog period select resets to 128 seconds
// RULE19 - host sets clear bit within each period to restart timer
// RULE20 - lock bit is read-only, from factory programming
// RULE21 - unlocked: enable resets to default, writes set and clear it
// RULE22 - locked, default 0: writes of 1 taken, writes of 0 ignored
// RULE23 - locked, default 1: watchdog can never be disabled
// RULE24 - software control 1 is cold reset, 2 is power-off
// RULE25 - clear bit drops by itself after restarting the timer
`timescale 1ns/100ps
`default_nettype none
`include "onoff_supervisor_defs.vh"

module onoff_supervisor_watchdog #(
  parameter [31:0] CHARGER_DB_CYC = `CHARGER_DB_CYC,
  parameter [31:0] EN_DB_CYC = `EN_DB_CYC,
  parameter [31:0] SHIP_EXIT_CYC = `SHIP_EXIT_CYC,
  parameter [31:0] GPI_DB_CYC = `GPI_DB_CYC,
  parameter [31:0] CYC_PER_S = `CYC_PER_S
) (
  input wire clk_sys, // 20 MHz system clock
  input wire arst_n, // asynchronous reset, active low
  input wire [11:0] switcher_channel_enable_code, // 3 switchers x 3 bits
  input wire [2:0] linear_channel_enable_code, // linear channel code
  input wire always_on_supply_ok, // always-on supply above its threshold
  input wire [1:0] software_power_control, // host control field
  input wire software_power_control_wr, // pulse: field written
  input wire charger_input_raw, // raw charger valid comparator
  input wire enable_pin_n, // enable pin, active low
  input wire [1:0] gpi_raw, // general inputs
  input wire [1:0] input_debounce_enable, // per general input
  input wire system_rail_low, // system rail under about 1.8V
  input wire battery_rail_low, // battery under about 1.8V
  input wire host_access_req, // host wants a bus transaction
  input wire watchdog_lock_bit, // factory lock
  input wire watchdog_enable_default, // factory enable default
  input wire watchdog_enable_wdata, // written enable value
  input wire watchdog_enable_wr, // pulse: enable bit written
  input wire [1:0] watchdog_period_wdata, // written period select
  input wire watchdog_period_wr, // pulse: period written
  input wire watchdog_clear_wr, // pulse: clear bit written as 1
  output reg [3:0] channel_force_on_q, // per channel forced on
  output reg [3:0] channel_force_off_q, // per channel forced off
  output reg main_bias_on_q, // main bias request
  output reg ship_state_q, // in ship state
  output reg battery_disconnect_q, // battery cut from system rail
  output reg system_from_charger_q, // rail fed from charger
  output reg always_on_reset_q, // pulse: always-on reset
  output reg host_access_grant_q, // host bus transaction allowed
  output reg cold_reset_q, // pulse: software cold reset
  output reg power_off_q, // pulse: software power-off
  output reg shutdown_q, // pulse: watchdog shutdown
  output reg config_reset_q, // pulse: configuration reset
  output reg [1:0] charger_input_status_q, // 3 valid, 0 absent
  output reg enable_debounced_q, // debounced enable, active high
  output reg [1:0] gpi_level_q, // debounced general inputs
  output reg watchdog_enable_bit_q, // watchdog running
  output reg [1:0] watchdog_period_select_q, // period select
  output reg watchdog_clear_bit_q, // clear pending
  output reg watchdog_lock_bit_q // lock readback
);

  wire chg_db;
  wire en_db;
  wire [1:0] gpi_db;
  reg [1:0] chg_status_prev_q;
  reg [31:0] hold_cnt_q;
  reg [31:0] sec_cnt_q;
  reg [7:0] wd_sec_q;
  reg lock_cap_q;
  reg en_def_cap_q;
  reg straps_taken_q;
  reg [2:0] code;
  reg [3:0] on_d;
  reg [3:0] off_d;
  reg [7:0] wd_limit;
  integer i;
  wire host_open;

  // RULE8 watchdog writes refused in ship state
  assign host_open = !ship_state_q;

  // RULE13 charger debounce
  input_debouncer #(.DB_CYC(CHARGER_DB_CYC), .RST_VAL(1'b0)) u_chg_db (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .raw_in(charger_input_raw),
    .bypass(1'b0),
    .level_q(chg_db)
  );

  // RULE13 enable pin debounce
  input_debouncer #(.DB_CYC(EN_DB_CYC), .RST_VAL(1'b0)) u_en_db (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .raw_in(~enable_pin_n),
    .bypass(1'b0),
    .level_q(en_db)
  );

  // general inputs filtered only when their debounce bit is set
  genvar g;
  generate
    for (g = 0; g < `NUM_GPI; g = g + 1) begin : gen_gpi
      input_debouncer #(.DB_CYC(GPI_DB_CYC), .RST_VAL(1'b0)) u_gpi_db (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .raw_in(gpi_raw[g]),
        .bypass(~input_debounce_enable[g]),
        .level_q(gpi_db[g])
      );
    end
  endgenerate

  // channel decode: 3 switchers then the linear one
  always @* begin
    on_d = 4'h0;
    off_d = 4'h0;
    code = 3'h0;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      if (i < 3) begin
        code = switcher_channel_enable_code[i*3 +: 3];
      end else begin
        code = linear_channel_enable_code;
      end
      // RULE1 forced on
      on_d[i] = (code == `EN_FORCE_ON_A) || (code == `EN_FORCE_ON_B);
      // RULE3 forced off
      off_d[i] = (code == `EN_FORCE_OFF_A) || (code == `EN_FORCE_OFF_B);
    end
  end

  // RULE17 period is 16 s shifted by the select
  always @* begin
    wd_limit = 8'h00;
    case (watchdog_period_select_q)
      2'h0: wd_limit = 8'h10;
      2'h1: wd_limit = 8'h20;
      2'h2: wd_limit = 8'h40;
      2'h3: wd_limit = 8'h80;
      default: wd_limit = 8'h80;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      channel_force_on_q <= 4'h0;
      channel_force_off_q <= 4'h0;
      main_bias_on_q <= 1'b0;
      charger_input_status_q <= `CHARGER_ABSENT;
      chg_status_prev_q <= `CHARGER_ABSENT;
      enable_debounced_q <= 1'b0;
      gpi_level_q <= 2'h0;
    end else begin
      // RULE1 start only with supply good
      channel_force_on_q <= always_on_supply_ok ? on_d : 4'h0;
      // RULE3 hold off
      channel_force_off_q <= off_d;
      // RULE2 bias follows forced channels
      main_bias_on_q <= always_on_supply_ok && (|on_d);
      charger_input_status_q <= chg_db ? `CHARGER_VALID : `CHARGER_ABSENT;
      chg_status_prev_q <= charger_input_status_q;
      enable_debounced_q <= en_db;
      gpi_level_q <= gpi_db;
    end
  end

  // ship state and software commands
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ship_state_q <= 1'b0;
      battery_disconnect_q <= 1'b0;
      system_from_charger_q <= 1'b0;
      always_on_reset_q <= 1'b0;
      host_access_grant_q <= 1'b0;
      cold_reset_q <= 1'b0;
      power_off_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
    end else begin
      always_on_reset_q <= 1'b0;
      cold_reset_q <= 1'b0;
      power_off_q <= 1'b0;
      // RULE8 no host access in ship
      host_access_grant_q <= host_access_req && !ship_state_q;
      if (!ship_state_q) begin
        hold_cnt_q <= 32'h0000_0000;
        if (software_power_control_wr) begin
          case (software_power_control)
            // RULE24 cold reset
            `SFT_COLD_RESET: cold_reset_q <= 1'b1;
            // RULE24 power-off
            `SFT_POWER_OFF: power_off_q <= 1'b1;
            `SFT_SHIP: begin
              ship_state_q <= 1'b1;
              battery_disconnect_q <= 1'b1;
              // RULE5 RULE6 rail source by charger
              system_from_charger_q <=
                (charger_input_status_q == `CHARGER_VALID);
              // RULE7 always-on reset
              always_on_reset_q <= 1'b1;
            end
            default: cold_reset_q <= 1'b0;
          endcase
        end
      end else begin
        // rail stays charger-fed only while charger holds
        if (charger_input_status_q != `CHARGER_VALID) begin
          system_from_charger_q <= 1'b0;
        end
        // RULE11 enable hold timer
        if (enable_debounced_q && hold_cnt_q < SHIP_EXIT_CYC) begin
          hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
        end else if (!enable_debounced_q) begin
          hold_cnt_q <= 32'h0000_0000;
        end
        // RULE12 battery removed
        if (battery_rail_low) begin
          ship_state_q <= 1'b0;
          battery_disconnect_q <= 1'b0;
          system_from_charger_q <= 1'b0;
        // RULE9 exits need rail low
        end else if (system_rail_low &&
            // RULE10 charger 0 to 3
            ((chg_status_prev_q == `CHARGER_ABSENT &&
              charger_input_status_q == `CHARGER_VALID) ||
            // RULE11 long enable press
             hold_cnt_q >= SHIP_EXIT_CYC)) begin
          ship_state_q <= 1'b0;
          battery_disconnect_q <= 1'b0;
          system_from_charger_q <= 1'b0;
        end
      end
    end
  end

  // factory straps caught once after reset release
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      straps_taken_q <= 1'b0;
      lock_cap_q <= 1'b0;
      en_def_cap_q <= 1'b0;
    end else if (!straps_taken_q) begin
      straps_taken_q <= 1'b1;
      lock_cap_q <= watchdog_lock_bit;
      en_def_cap_q <= watchdog_enable_default;
    end
  end

  // watchdog; always-on reset restores its defaults too
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_enable_bit_q <= 1'b0;
      // RULE18 longest period
      watchdog_period_select_q <= `WDOG_PERIOD_RST;
      watchdog_clear_bit_q <= 1'b0;
      watchdog_lock_bit_q <= 1'b0;
      sec_cnt_q <= 32'h0000_0000;
      wd_sec_q <= 8'h00;
      shutdown_q <= 1'b0;
      config_reset_q <= 1'b0;
    end else begin
      shutdown_q <= 1'b0;
      config_reset_q <= always_on_reset_q;
      // RULE20 lock is read-only
      watchdog_lock_bit_q <= lock_cap_q;
      if (!straps_taken_q || always_on_reset_q) begin
        // RULE21 default from factory
        watchdog_enable_bit_q <= watchdog_enable_default;
        watchdog_period_select_q <= `WDOG_PERIOD_RST;
        watchdog_clear_bit_q <= 1'b0;
        sec_cnt_q <= 32'h0000_0000;
        wd_sec_q <= 8'h00;
      end else begin
        if (watchdog_period_wr && host_open) begin
          watchdog_period_select_q <= watchdog_period_wdata;
        end
        // RULE23 locked and on stays on
        if (lock_cap_q && en_def_cap_q) begin
          watchdog_enable_bit_q <= 1'b1;
        // RULE22 locked: only writes of 1
        end else if (lock_cap_q) begin
          if (watchdog_enable_wr && watchdog_enable_wdata && host_open) begin
            watchdog_enable_bit_q <= 1'b1;
          end
        // RULE21 unlocked: any write
        end else if (watchdog_enable_wr && host_open) begin
          watchdog_enable_bit_q <= watchdog_enable_wdata;
        end
        // RULE19 clear restarts timer
        if (watchdog_clear_bit_q || !watchdog_enable_bit_q) begin
          sec_cnt_q <= 32'h0000_0000;
          wd_sec_q <= 8'h00;
        end else if (sec_cnt_q >= CYC_PER_S - 32'h0000_0001) begin
          sec_cnt_q <= 32'h0000_0000;
          if (wd_sec_q + 8'h01 >= wd_limit) begin
            // RULE15 expiry shuts down
            shutdown_q <= 1'b1;
            config_reset_q <= 1'b1;
            wd_sec_q <= 8'h00;
          end else begin
            wd_sec_q <= wd_sec_q + 8'h01;
          end
        end else begin
          sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
        end
        // RULE25 clear self-clears, new write wins
        if (watchdog_clear_wr && host_open) begin
          watchdog_clear_bit_q <= 1'b1;
        end else if (watchdog_clear_bit_q) begin
          watchdog_clear_bit_q <= 1'b0;
        end
      end
    end
  end

endmodule // onoff_supervisor_watchdog

`default_nettype wire

//--- onoff_supervisor_watchdog_asserts.sv
// assertion checker for the on/off supervisor and watchdog
`timescale 1ns/100ps
`default_nettype none
module onoff_supervisor_watchdog_asserts #(
  parameter [31:0] EN_DB_CYC = 32'h0000_0008
) (
  input wire clk_sys, // clock
  input wire arst_n, // reset
  input wire [11:0] switcher_channel_enable_code, // codes
  input wire [2:0] linear_channel_enable_code, // code
  input wire always_on_supply_ok, // supply good
  input wire [1:0] software_power_control, // control
  input wire software_power_control_wr, // strobe
  input wire enable_pin_n, // pin
  input wire system_rail_low, // rail low
  input wire battery_rail_low, // battery low
  input wire [1:0] watchdog_period_wdata, // period
  input wire watchdog_period_wr, // strobe
  input wire watchdog_clear_wr, // strobe
  input wire [3:0] channel_force_on_q, // forced on
  input wire [3:0] channel_force_off_q, // forced off
  input wire main_bias_on_q, // bias
  input wire ship_state_q, // ship
  input wire battery_disconnect_q, // battery cut
  input wire system_from_charger_q, // charger feed
  input wire always_on_reset_q, // always-on reset
  input wire host_access_grant_q, // grant
  input wire cold_reset_q, // cold reset
  input wire power_off_q, // power-off
  input wire shutdown_q, // shutdown
  input wire config_reset_q, // config reset
  input wire [1:0] charger_input_status_q, // charger status
  input wire enable_debounced_q, // debounced pin
  input wire [1:0] watchdog_period_select_q, // period
  input wire watchdog_enable_bit_q, // enable
  input wire watchdog_clear_bit_q, // clear
  input wire watchdog_lock_bit_q // lock
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic pin_prev_q;
  logic [31:0] pin_stable_q;
  // raw pin age; a lower bound, since the synchroniser adds a little
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev_q <= 1'b1;
      pin_stable_q <= 32'h0;
    end else begin
      pin_prev_q <= enable_pin_n;
      pin_stable_q <= (enable_pin_n != pin_prev_q) ? 32'h0 :
        pin_stable_q + 32'h1;
    end
  end
  sequence ship_req_s;
    software_power_control_wr && !ship_state_q &&
      software_power_control == 2'h3;
  endsequence
  sequence ship_enter_s;
    ship_state_q && battery_disconnect_q && always_on_reset_q
      ##1 config_reset_q;
  endsequence
  sequence clear_pulse_s;
    watchdog_clear_bit_q ##1 !watchdog_clear_bit_q;
  endsequence
  a_force_on_code: assert property (
    switcher_channel_enable_code[2:1] == 2'h3 && always_on_supply_ok
      |=> channel_force_on_q[0]) else $error("forced on missing");
  a_bias_follows: assert property (
    |channel_force_on_q |-> ##[0:1] main_bias_on_q)
    else $error("bias not raised");
  a_force_off_code: assert property (
    linear_channel_enable_code[2:1] == 2'h2 |=> channel_force_off_q[3]
      && !channel_force_on_q[3]) else $error("forced off missing");
  a_ship_entry: assert property (
    ship_req_s |=> ship_enter_s) else $error("ship entry wrong");
  a_ship_feed: assert property (
    ship_req_s |=> system_from_charger_q ==
      $past(charger_input_status_q == 2'h3)) else $error("feed wrong");
  a_host_blocked: assert property (
    ship_state_q |=> !host_access_grant_q) else $error("grant in ship");
  a_exit_rail: assert property (
    $fell(ship_state_q) |-> $past(system_rail_low) ||
      $past(battery_rail_low)) else $error("exit with rails high");
  a_soft_codes: assert property (
    software_power_control_wr && !ship_state_q |=> cold_reset_q ==
      ($past(software_power_control) == 2'h1) && power_off_q ==
      ($past(software_power_control) == 2'h2)) else $error("soft code");
  a_pin_stable: assert property (
    $changed(enable_debounced_q) |-> pin_stable_q >= EN_DB_CYC)
    else $error("debounce too short");
  a_dog_expiry: assert property (
    shutdown_q |-> config_reset_q) else $error("no config reset");
  a_period_write: assert property (
    watchdog_period_wr && !ship_state_q && !software_power_control_wr
      |=> watchdog_period_select_q == $past(watchdog_period_wdata))
    else $error("period not taken");
  a_lock_hold: assert property (
    watchdog_lock_bit_q && watchdog_enable_bit_q && !ship_state_q &&
      !software_power_control_wr |=> watchdog_enable_bit_q)
    else $error("locked enable dropped");
  a_clear_self: assert property (
    watchdog_clear_wr && watchdog_enable_bit_q && !ship_state_q
      |=> clear_pulse_s)
    else $error("clear bit stuck");
endmodule // onoff_supervisor_watchdog_asserts
bind onoff_supervisor_watchdog onoff_supervisor_watchdog_asserts #(
  .EN_DB_CYC(EN_DB_CYC)
) chk_u (.*);
`default_nettype wire

//--- onoff_host_model.sv
// host processor model issuing control writes
`timescale 1ns/100ps
`default_nettype none
module onoff_host_model (
  input wire logic clk_sys, // clock
  output logic [1:0] software_power_control, // control field
  output logic software_power_control_wr, // strobe
  output logic host_access_req, // bus request
  output logic watchdog_enable_wdata, // enable value
  output logic watchdog_enable_wr, // strobe
  output logic [1:0] watchdog_period_wdata, // period value
  output logic watchdog_period_wr, // strobe
  output logic watchdog_clear_wr // strobe
);
  initial begin
    {software_power_control, software_power_control_wr} = 3'h0;
    host_access_req = 1'b1;
    {watchdog_enable_wdata, watchdog_enable_wr} = 2'h0;
    {watchdog_period_wdata, watchdog_period_wr} = 3'h0;
    watchdog_clear_wr = 1'b0;
  end
  // data lines are inverted on release so stale values cannot match
  // software control code write
  task automatic sft(input logic [1:0] v);
    @(posedge clk_sys) #1;
    software_power_control = v;
    software_power_control_wr = 1'b1;
    @(posedge clk_sys) #1;
    software_power_control_wr = 1'b0;
    software_power_control = ~v;
  endtask
  task automatic wen(input logic v);
    @(posedge clk_sys) #1;
    watchdog_enable_wdata = v;
    watchdog_enable_wr = 1'b1;
    @(posedge clk_sys) #1;
    watchdog_enable_wr = 1'b0;
    watchdog_enable_wdata = ~v;
  endtask
  task automatic per(input logic [1:0] v);
    @(posedge clk_sys) #1;
    watchdog_period_wdata = v;
    watchdog_period_wr = 1'b1;
    @(posedge clk_sys) #1;
    watchdog_period_wr = 1'b0;
    watchdog_period_wdata = ~v;
  endtask
  task automatic clr();
    @(posedge clk_sys) #1;
    watchdog_clear_wr = 1'b1;
    @(posedge clk_sys) #1;
    watchdog_clear_wr = 1'b0;
  endtask
endmodule // onoff_host_model
`default_nettype wire

//--- test_onoff_supervisor_watchdog.sv
// testbench for the on/off supervisor and watchdog
`timescale 1ns/100ps
`default_nettype none
`include "onoff_supervisor_defs.vh"
module test_onoff_supervisor_watchdog;
  localparam [31:0] DB = 32'h8;
  localparam [31:0] EXIT = 32'hC;
  localparam [31:0] CPS = 32'h14;
  logic clk_sys = 1'b0, arst_n = 1'b0, always_on_supply_ok = 1'b1;
  logic [11:0] switcher_channel_enable_code = 12'h0;
  logic [2:0] linear_channel_enable_code = 3'h0;
  logic charger_input_raw = 1'b0, enable_pin_n = 1'b1;
  logic [1:0] gpi_raw = 2'h0, input_debounce_enable = 2'h1;
  logic system_rail_low = 1'b0, battery_rail_low = 1'b0;
  logic watchdog_lock_bit = 1'b0, watchdog_enable_default = 1'b0;
  wire [1:0] software_power_control, watchdog_period_wdata;
  wire software_power_control_wr, host_access_req, watchdog_enable_wdata;
  wire watchdog_enable_wr, watchdog_period_wr, watchdog_clear_wr;
  wire [3:0] channel_force_on_q, channel_force_off_q;
  wire [1:0] charger_input_status_q, gpi_level_q, watchdog_period_select_q;
  wire main_bias_on_q, ship_state_q, battery_disconnect_q, power_off_q;
  wire system_from_charger_q, always_on_reset_q, host_access_grant_q;
  wire cold_reset_q, shutdown_q, config_reset_q, enable_debounced_q;
  wire watchdog_enable_bit_q, watchdog_clear_bit_q, watchdog_lock_bit_q;
  int checked = 0, num_errors = 0;
  onoff_supervisor_watchdog #(
    .CHARGER_DB_CYC(DB), .EN_DB_CYC(DB), .SHIP_EXIT_CYC(EXIT),
    .GPI_DB_CYC(DB), .CYC_PER_S(CPS)
  ) dut_u (.*);
  onoff_host_model host_u (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp,
      input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask
  task automatic wait_ship(input logic exp, input int lim);
    int n = 0;
    while (ship_state_q !== exp && n < lim) begin
      tick(1);
      n++;
    end
    chk(ship_state_q, exp, "ship state");
  endtask
  task automatic do_reset(input logic lk, input logic df);
    arst_n = 1'b0;
    watchdog_lock_bit = lk;
    watchdog_enable_default = df;
    tick(5);
    arst_n = 1'b1;
    tick(3);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // whole run is near 830 cycles; allow about eighteen times that
  initial begin
    #750000;
    num_errors++;
    stop_test;
  end
  initial begin
    logic e;
    int n;
    for (int s = 3; s >= 0; s--) begin
      do_reset(s[1], s[0]);
      e = s[0];
      chk(watchdog_lock_bit_q, s[1], "lock");
      chk(watchdog_period_select_q, `WDOG_PERIOD_RST, "period rst");
      chk(watchdog_enable_bit_q, e, "enable rst");
      for (int w = 0; w < 3; w++) begin
        host_u.wen(w == 1);
        tick(1);
        e = s[1] ? (e | (w == 1)) : (w == 1);
        chk(watchdog_enable_bit_q, e, "enable wr");
      end
    end
    for (int c = 0; c < 8; c++) begin
      switcher_channel_enable_code = {3{c[2:0]}};
      linear_channel_enable_code = c[2:0];
      tick(3);
      chk(channel_force_on_q, {4{c > 5}}, "on");
      chk(channel_force_off_q, {4{c == 4 || c == 5}}, "off");
      chk(main_bias_on_q, c > 5, "bias");
    end
    always_on_supply_ok = 1'b0;
    tick(3);
    chk(channel_force_on_q, 4'h0, "supply low");
    always_on_supply_ok = 1'b1;
    {enable_pin_n, gpi_raw, charger_input_raw} = 4'h7;
    tick(DB - 3);
    {enable_pin_n, gpi_raw, charger_input_raw} = 4'h8;
    tick(DB + 6);
    chk({enable_debounced_q, gpi_level_q}, 3'h0, "glitch");
    {enable_pin_n, gpi_raw, charger_input_raw} = 4'h7;
    tick(DB - 1);
    chk(gpi_level_q, 2'h2, "bypass");
    tick(8);
    chk({enable_debounced_q, gpi_level_q}, 3'h7, "held");
    chk(charger_input_status_q, `CHARGER_VALID, "charger");
    enable_pin_n = 1'b1;
    tick(DB + 6);
    chk(enable_debounced_q, 1'b0, "pin fall");
    host_u.per(2'h0);
    tick(1);
    chk(watchdog_period_select_q, 2'h0, "period wr");
    host_u.wen(1'b1);
    tick(250);
    host_u.clr();
    n = 0;
    while (shutdown_q !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(n > 314 && n < 326, 1'b1, "expiry");
    chk(config_reset_q, 1'b1, "cfg reset");
    host_u.wen(1'b0);
    // pulses stand for one cycle: look right after the strobe edge
    for (int c = 1; c < 3; c++) begin
      host_u.sft(c[1:0]);
      chk({power_off_q, cold_reset_q}, c[1:0], "soft code");
    end
    chk(host_access_grant_q, 1'b1, "grant");
    host_u.sft(`SFT_SHIP);
    chk(always_on_reset_q, 1'b1, "always-on rst");
    tick(2);
    chk({ship_state_q, battery_disconnect_q, system_from_charger_q},
      3'h7, "ship valid");
    chk(watchdog_period_select_q, `WDOG_PERIOD_RST, "ship rst");
    chk(host_access_grant_q, 1'b0, "ship grant");
    host_u.sft(2'h1);
    chk(cold_reset_q, 1'b0, "refused");
    host_u.per(2'h1);
    tick(1);
    chk(watchdog_period_select_q, `WDOG_PERIOD_RST, "ship per");
    system_rail_low = 1'b1;
    charger_input_raw = 1'b0;
    tick(DB + 6);
    chk(ship_state_q, 1'b1, "charger loss");
    charger_input_raw = 1'b1;
    wait_ship(1'b0, 30);
    {system_rail_low, charger_input_raw} = 2'h0;
    tick(DB + 6);
    host_u.sft(`SFT_SHIP);
    tick(2);
    chk({ship_state_q, battery_disconnect_q, system_from_charger_q},
      3'h6, "ship invalid");
    enable_pin_n = 1'b0;
    tick(DB + EXIT + 10);
    chk(ship_state_q, 1'b1, "rail high");
    system_rail_low = 1'b1;
    wait_ship(1'b0, 20);
    {enable_pin_n, system_rail_low} = 2'h2;
    tick(DB + 6);
    host_u.sft(`SFT_SHIP);
    tick(2);
    chk(ship_state_q, 1'b1, "ship again");
    battery_rail_low = 1'b1;
    wait_ship(1'b0, 5);
    stop_test;
  end
endmodule // test_onoff_supervisor_watchdog
`default_nettype wire
